// *** rtl/mac_ctrl_pkg.sv ***
package mac_ctrl_pkg;

  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_PHY_ACCESS = 8'h94;
  localparam logic [7:0] OFF_PHY_DATA = 8'h98;
  localparam logic [7:0] OFF_PAUSE_CTRL = 8'h9c;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int ACC_BUSY_BIT = 0;
  localparam int ACC_WNR_BIT = 1;
  localparam int ACC_IDX_LSB = 6;
  localparam int ACC_PHYADDR_LSB = 11;
  localparam int FIELD5_W = 5;
  localparam int DATA_W = 16;
  localparam int PAUSE_BUSY_BIT = 0;
  localparam int PAUSE_EN_BIT = 1;
  localparam int PAUSE_PASS_BIT = 2;
  localparam int PAUSE_TIME_LSB = 16;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [4:0] RST_PHY_ADDR = 5'h00;
  localparam logic [4:0] RST_REG_INDEX = 5'h00;
  localparam logic [15:0] RST_PHY_DATA = 16'h0000;
  localparam logic [15:0] RST_PAUSE_TIME = 16'h0000;
  localparam logic [31:0] RST_PRDATA = 32'h0000_0000;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int SLOT_BITS = 512;
  localparam int BIT_NS_FAST = 10;
  localparam int BIT_NS_SLOW = 100;
  localparam int SLOT_CYC_FAST = SLOT_BITS * BIT_NS_FAST / CLK_PERIOD_NS;
  localparam int SLOT_CYC_SLOW = SLOT_BITS * BIT_NS_SLOW / CLK_PERIOD_NS;

  typedef enum logic [2:0]
  {
    MG_IDLE = 3'b001,
    MG_WAIT = 3'b010,
    MG_DONE = 3'b100
  } mgmt_state_t;

  typedef struct packed
  {
    logic valid;
    logic write;
    logic [4:0] phy_addr;
    logic [4:0] reg_index;
    logic [15:0] wdata;
  } phy_mgmt_req_t;

  typedef struct packed
  {
    logic ack;
    logic [15:0] rdata;
  } phy_mgmt_resp_t;

  typedef struct packed
  {
    logic done;
    logic pause_ok;
    logic [15:0] pause_quanta;
    logic addr_pass;
    logic promiscuous;
  } rx_frame_info_t;

  typedef struct packed
  {
    logic valid;
    logic packet_filter;
    logic control_frame;
  } rx_status_t;

endpackage

// *** rtl/pause_slot_timer.sv ***
`timescale 1ns/1ns
module pause_slot_timer #(
  parameter int FAST_SLOT_CYCLES = mac_ctrl_pkg::SLOT_CYC_FAST,
  parameter int SLOW_SLOT_CYCLES = mac_ctrl_pkg::SLOT_CYC_SLOW
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic [15:0] quanta,
  input wire logic speed_100,
  output logic active
);

  if (FAST_SLOT_CYCLES < 1 || SLOW_SLOT_CYCLES < 1 || SLOW_SLOT_CYCLES > 65535)
  begin : g_bad_slot
    $error("slot cycle count out of range");
  end

  localparam logic [15:0] FAST_LAST = 16'(FAST_SLOT_CYCLES - 1);
  localparam logic [15:0] SLOW_LAST = 16'(SLOW_SLOT_CYCLES - 1);

  logic [15:0] remaining;
  logic [15:0] slot_cnt;
  logic [15:0] slot_last;

  // slot length follows the live link speed
  assign slot_last = speed_100 ? FAST_LAST : SLOW_LAST;
  assign active = (remaining != 16'h0000);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      remaining <= 16'h0000;
      slot_cnt <= 16'h0000;
    end
    else if (load)
    begin
      remaining <= quanta;
      slot_cnt <= 16'h0000;
    end
    else if (active)
    begin
      if (slot_cnt >= slot_last)
      begin
        slot_cnt <= 16'h0000;
        remaining <= remaining - 16'h0001;
      end
      else
      begin
        slot_cnt <= slot_cnt + 16'h0001;
      end
    end
  end

endmodule

// *** rtl/mac_phy_mgmt_and_pause_ctrl.sv ***
// Design decision made here: register access over APB.
`timescale 1ns/1ns
module mac_phy_mgmt_and_pause_ctrl #(
  parameter int SLOW_SLOT_CYCLES = mac_ctrl_pkg::SLOT_CYC_SLOW
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [mac_ctrl_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output mac_ctrl_pkg::phy_mgmt_req_t phy_req,
  input wire mac_ctrl_pkg::phy_mgmt_resp_t phy_resp,
  output logic pause_tx_req,
  output logic [15:0] pause_tx_time,
  input wire logic pause_tx_done,
  input wire mac_ctrl_pkg::rx_frame_info_t rx_info,
  output mac_ctrl_pkg::rx_status_t rx_status,
  input wire logic full_duplex,
  input wire logic speed_100,
  output logic tx_pause_stall
);

  // ************************************************************
  // register state
  // ************************************************************
  logic [4:0] phy_addr;
  logic [4:0] phy_reg_index;
  logic phy_write_not_read;
  logic phy_mgmt_busy;
  logic [15:0] phy_data;
  logic [15:0] pause_time_value;
  logic pass_control_frames;
  logic pause_function_enable;
  logic pause_send_busy;
  mac_ctrl_pkg::mgmt_state_t mgmt_state;
  logic setup;
  logic wr;
  logic mapped;
  logic [31:0] next_prdata;
  logic start_phy;
  logic start_pause;
  logic pause_allowed;
  logic timer_load;
  logic timer_active;
  default clocking main_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite && pready;
  assign mapped = (paddr == mac_ctrl_pkg::OFF_PHY_ACCESS) ||
                  (paddr == mac_ctrl_pkg::OFF_PHY_DATA) ||
                  (paddr == mac_ctrl_pkg::OFF_PAUSE_CTRL);
  assign start_phy = wr && (paddr == mac_ctrl_pkg::OFF_PHY_ACCESS) && !phy_mgmt_busy &&
                     pwdata[mac_ctrl_pkg::ACC_BUSY_BIT];
  assign start_pause = wr && (paddr == mac_ctrl_pkg::OFF_PAUSE_CTRL) && !pause_send_busy &&
                       pwdata[mac_ctrl_pkg::PAUSE_BUSY_BIT];
  assign pause_allowed = pause_function_enable && full_duplex;

  // ************************************************************
  // apb slave: one registered answer in the access phase
  // ************************************************************
  always_comb
  begin
    next_prdata = 32'h0000_0000;
    case (paddr)
      mac_ctrl_pkg::OFF_PHY_ACCESS:
      begin
        next_prdata[mac_ctrl_pkg::ACC_PHYADDR_LSB +: mac_ctrl_pkg::FIELD5_W] = phy_addr;
        next_prdata[mac_ctrl_pkg::ACC_IDX_LSB +: mac_ctrl_pkg::FIELD5_W] = phy_reg_index;
        next_prdata[mac_ctrl_pkg::ACC_WNR_BIT] = phy_write_not_read;
        next_prdata[mac_ctrl_pkg::ACC_BUSY_BIT] = phy_mgmt_busy;
      end
      mac_ctrl_pkg::OFF_PHY_DATA:
        next_prdata[mac_ctrl_pkg::DATA_W-1:0] = phy_data;
      mac_ctrl_pkg::OFF_PAUSE_CTRL:
      begin
        next_prdata[mac_ctrl_pkg::PAUSE_TIME_LSB +: mac_ctrl_pkg::DATA_W] = pause_time_value;
        next_prdata[mac_ctrl_pkg::PAUSE_PASS_BIT] = pass_control_frames;
        next_prdata[mac_ctrl_pkg::PAUSE_EN_BIT] = pause_function_enable;
        next_prdata[mac_ctrl_pkg::PAUSE_BUSY_BIT] = pause_send_busy;
      end
      default:
        next_prdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= mac_ctrl_pkg::RST_PRDATA;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup && !mapped;
      // read value is captured in the setup cycle, one cycle before the master takes it
      if (setup)
      begin
        prdata <= next_prdata;
      end
    end
  end

  // ************************************************************
  // phy management access
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phy_addr <= mac_ctrl_pkg::RST_PHY_ADDR;
      phy_reg_index <= mac_ctrl_pkg::RST_REG_INDEX;
      phy_write_not_read <= 1'b0;
    end
    else if (wr && paddr == mac_ctrl_pkg::OFF_PHY_ACCESS && !phy_mgmt_busy)
    begin
      // address is forwarded as written; software keeps it at the internal phy
      phy_addr <= pwdata[mac_ctrl_pkg::ACC_PHYADDR_LSB +: mac_ctrl_pkg::FIELD5_W];
      phy_reg_index <= pwdata[mac_ctrl_pkg::ACC_IDX_LSB +: mac_ctrl_pkg::FIELD5_W];
      phy_write_not_read <= pwdata[mac_ctrl_pkg::ACC_WNR_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phy_data <= mac_ctrl_pkg::RST_PHY_DATA;
    end
    else if (mgmt_state == mac_ctrl_pkg::MG_WAIT && phy_resp.ack && !phy_write_not_read)
      phy_data <= phy_resp.rdata;
    else if (wr && paddr == mac_ctrl_pkg::OFF_PHY_DATA && !phy_mgmt_busy)
      phy_data <= pwdata[mac_ctrl_pkg::DATA_W-1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mgmt_state <= mac_ctrl_pkg::MG_IDLE;
      phy_mgmt_busy <= 1'b0;
      phy_req <= '0;
    end
    else
    begin
      case (mgmt_state)
        mac_ctrl_pkg::MG_IDLE:
        begin
          if (start_phy)
          begin
            mgmt_state <= mac_ctrl_pkg::MG_WAIT;
            phy_mgmt_busy <= 1'b1;
            phy_req.valid <= 1'b1;
            phy_req.write <= pwdata[mac_ctrl_pkg::ACC_WNR_BIT];
            phy_req.phy_addr <= pwdata[mac_ctrl_pkg::ACC_PHYADDR_LSB +: mac_ctrl_pkg::FIELD5_W];
            phy_req.reg_index <= pwdata[mac_ctrl_pkg::ACC_IDX_LSB +: mac_ctrl_pkg::FIELD5_W];
            phy_req.wdata <= phy_data;
          end
        end
        mac_ctrl_pkg::MG_WAIT:
        begin
          if (phy_resp.ack)
          begin
            mgmt_state <= mac_ctrl_pkg::MG_DONE;
            phy_req.valid <= 1'b0;
          end
        end
        mac_ctrl_pkg::MG_DONE:
        begin
          // busy drops one cycle after read data is stored
          mgmt_state <= mac_ctrl_pkg::MG_IDLE;
          phy_mgmt_busy <= 1'b0;
        end
        default:
        begin
          mgmt_state <= mac_ctrl_pkg::MG_IDLE;
          phy_mgmt_busy <= 1'b0;
          phy_req.valid <= 1'b0;
        end
      endcase
    end
  end

  // ************************************************************
  // pause frame transmit request
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pause_time_value <= mac_ctrl_pkg::RST_PAUSE_TIME;
      pass_control_frames <= 1'b0;
      pause_function_enable <= 1'b0;
    end
    else if (wr && paddr == mac_ctrl_pkg::OFF_PAUSE_CTRL && !pause_send_busy)
    begin
      pause_time_value <= pwdata[mac_ctrl_pkg::PAUSE_TIME_LSB +: mac_ctrl_pkg::DATA_W];
      pass_control_frames <= pwdata[mac_ctrl_pkg::PAUSE_PASS_BIT];
      pause_function_enable <= pwdata[mac_ctrl_pkg::PAUSE_EN_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pause_send_busy <= 1'b0;
      pause_tx_req <= 1'b0;
      pause_tx_time <= 16'h0000;
    end
    else if (start_pause)
    begin
      pause_send_busy <= 1'b1;
      pause_tx_req <= 1'b1;
      pause_tx_time <= pwdata[mac_ctrl_pkg::PAUSE_TIME_LSB +: mac_ctrl_pkg::DATA_W];
    end
    else if (pause_send_busy && pause_tx_done)
    begin
      pause_send_busy <= 1'b0;
      pause_tx_req <= 1'b0;
    end
  end

  // ************************************************************
  // receive pause decode and status
  // ************************************************************
  // leaving full duplex or disabling ends any running pause at once
  assign timer_load = !pause_allowed ||
                      (rx_info.done && rx_info.pause_ok);

  pause_slot_timer #(
    .FAST_SLOT_CYCLES(mac_ctrl_pkg::SLOT_CYC_FAST),
    .SLOW_SLOT_CYCLES(SLOW_SLOT_CYCLES)
  ) pause_slot_timer_i (
    .pclk(pclk),
    .presetn(presetn),
    .load(timer_load),
    .quanta(pause_allowed ? rx_info.pause_quanta : 16'h0000),
    .speed_100(speed_100),
    .active(timer_active)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_pause_stall <= 1'b0;
      rx_status <= '0;
    end
    else
    begin
      tx_pause_stall <= timer_active;
      rx_status.valid <= rx_info.done;
      rx_status.control_frame <= rx_info.done && rx_info.pause_ok && pause_function_enable;
      if (rx_info.promiscuous)
      begin
        rx_status.packet_filter <= 1'b1;
      end
      else if (rx_info.pause_ok && pause_function_enable)
      begin
        rx_status.packet_filter <= pass_control_frames;
      end
      else
      begin
        rx_status.packet_filter <= rx_info.addr_pass;
      end
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  property p_busy_held;
    (mgmt_state == mac_ctrl_pkg::MG_WAIT && !phy_resp.ack) |=> phy_mgmt_busy && phy_req.valid;
  endproperty
  a_busy_held: assert property (p_busy_held) else $error("phy busy dropped early");
  property p_read_before_clear;
    (mgmt_state == mac_ctrl_pkg::MG_WAIT && phy_resp.ack && !phy_write_not_read) |=>
      (phy_data == $past(phy_resp.rdata)) && phy_mgmt_busy ##1 !phy_mgmt_busy;
  endproperty
  a_read_before_clear: assert property (p_read_before_clear) else $error("data late");
  property p_req_fields;
    start_phy |=> phy_req.valid && phy_req.reg_index == phy_reg_index &&
      phy_req.write == phy_write_not_read;
  endproperty
  a_req_fields: assert property (p_req_fields) else $error("request wrong");
  property p_write_data;
    (phy_req.valid && phy_req.write) |-> phy_req.wdata == phy_data;
  endproperty
  a_write_data: assert property (p_write_data) else $error("phy write data differs");
  property p_data_upper_zero;
    (setup && paddr == mac_ctrl_pkg::OFF_PHY_DATA) |=> prdata[31:16] == 16'h0000;
  endproperty
  a_data_upper_zero: assert property (p_data_upper_zero) else $error("reserved set");
  property p_pause_start;
    start_pause |=> pause_tx_req && pause_send_busy && pause_tx_time == pause_time_value;
  endproperty
  a_pause_start: assert property (p_pause_start) else $error("no pause start");
  property p_pause_busy_clear;
    (pause_send_busy && pause_tx_done && !start_pause) |=> !pause_send_busy && !pause_tx_req;
  endproperty
  a_pause_busy_clear: assert property (p_pause_busy_clear) else $error("busy stuck");
  property p_stall_on_pause;
    (rx_info.done && rx_info.pause_ok && pause_allowed && rx_info.pause_quanta != 16'h0000) |=>
      ##1 tx_pause_stall;
  endproperty
  a_stall_on_pause: assert property (p_stall_on_pause) else $error("no stall");
  property p_no_stall_disabled;
    (!pause_allowed) [*3] |-> !tx_pause_stall;
  endproperty
  a_no_stall_disabled: assert property (p_no_stall_disabled) else $error("stalled");
  property p_filter_bit;
    (rx_info.done && rx_info.pause_ok && pause_function_enable && !rx_info.promiscuous) |=>
      rx_status.valid && rx_status.packet_filter == $past(pass_control_frames);
  endproperty
  a_filter_bit: assert property (p_filter_bit) else $error("filter bit wrong");
  property p_promisc_wins;
    (rx_info.done && rx_info.promiscuous) |=> rx_status.valid && rx_status.packet_filter;
  endproperty
  a_promisc_wins: assert property (p_promisc_wins) else $error("filter bit clear");

  c_phy_read: cover property (start_phy ##1 !phy_req.write ##[1:20] !phy_mgmt_busy);
  c_phy_write: cover property (start_phy ##1 phy_req.write ##[1:20] !phy_mgmt_busy);
  c_pause_send: cover property (start_pause ##[1:50] !pause_send_busy);
  c_rx_stall: cover property (timer_load && pause_allowed ##2 tx_pause_stall);

endmodule

// *** testbench/phy_link_model.sv ***
`timescale 1ns/1ns
// ************************************************************
// internal phy and link transmitter stand-in
// ************************************************************
module phy_link_model
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] delay,
  input wire mac_ctrl_pkg::phy_mgmt_req_t phy_req,
  output mac_ctrl_pkg::phy_mgmt_resp_t phy_resp,
  input wire logic pause_tx_req,
  output logic pause_tx_done
);
  logic [15:0] regs [32];
  logic [3:0] mg_cnt;
  logic [3:0] tx_cnt;
  logic mg_seen;
  logic tx_seen;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mg_cnt <= 4'h0;
      mg_seen <= 1'b0;
      phy_resp <= '0;
    end
    else
    begin
      phy_resp.ack <= 1'b0;
      // released data toggles so a late sample never matches by luck
      phy_resp.rdata <= ~phy_resp.rdata;
      if (!phy_req.valid)
      begin
        mg_cnt <= 4'h0;
        mg_seen <= 1'b0;
      end
      else if (!mg_seen && mg_cnt >= delay)
      begin
        mg_seen <= 1'b1;
        phy_resp.ack <= 1'b1;
        if (phy_req.write)
          regs[phy_req.reg_index] <= phy_req.wdata;
        else
          phy_resp.rdata <= regs[phy_req.reg_index];
      end
      else
        mg_cnt <= mg_cnt + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_cnt <= 4'h0;
      tx_seen <= 1'b0;
      pause_tx_done <= 1'b0;
    end
    else
    begin
      pause_tx_done <= 1'b0;
      if (!pause_tx_req)
      begin
        tx_cnt <= 4'h0;
        tx_seen <= 1'b0;
      end
      else if (!tx_seen && tx_cnt >= delay)
      begin
        tx_seen <= 1'b1;
        pause_tx_done <= 1'b1;
      end
      else
        tx_cnt <= tx_cnt + 4'h1;
    end
  end
endmodule

// *** testbench/test_mac_phy_mgmt_and_pause_ctrl.sv ***
`timescale 1ns/1ns
module test_mac_phy_mgmt_and_pause_ctrl;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  mac_ctrl_pkg::phy_mgmt_req_t phy_req;
  mac_ctrl_pkg::phy_mgmt_resp_t phy_resp;
  logic pause_tx_req;
  logic [15:0] pause_tx_time;
  logic pause_tx_done;
  mac_ctrl_pkg::rx_frame_info_t rx_info = '0;
  mac_ctrl_pkg::rx_status_t rx_status;
  logic full_duplex = 1'b1;
  logic speed_100 = 1'b0;
  logic tx_pause_stall;
  logic [3:0] delay = 4'h4;
  int seed = 32'h64e3;
  int n_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [32:0] rd_q [$];
  logic [1:0] st_q [$];
  logic [31:0] rd;

  always #5 pclk = ~pclk;

  mac_phy_mgmt_and_pause_ctrl #(.SLOW_SLOT_CYCLES(8)) mac_phy_mgmt_and_pause_ctrl_i
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .phy_req(phy_req), .phy_resp(phy_resp), .pause_tx_req(pause_tx_req),
    .pause_tx_time(pause_tx_time), .pause_tx_done(pause_tx_done), .rx_info(rx_info),
    .rx_status(rx_status), .full_duplex(full_duplex), .speed_100(speed_100),
    .tx_pause_stall(tx_pause_stall)
  );

  phy_link_model phy_link_model_i
  (
    .pclk(pclk), .presetn(presetn), .delay(delay), .phy_req(phy_req),
    .phy_resp(phy_resp), .pause_tx_req(pause_tx_req), .pause_tx_done(pause_tx_done)
  );

  // ************************************************************
  // checking and closing
  // ************************************************************
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge pclk)
  begin
    cycles++;
    if (cycles > 20000)
    begin
      n_errors++;
      results();
    end
  end

  always @(posedge pclk)
    if (psel && penable && !pwrite && pready === 1'b1 && rd_q.size() > 0)
      check({pslverr, prdata}, rd_q.pop_front());

  always @(posedge pclk)
    if (rx_status.valid === 1'b1)
      check({rx_status.packet_filter, rx_status.control_frame},
        st_q.size() > 0 ? st_q.pop_front() : 2'bxx);

  // ************************************************************
  // bus and frame drivers
  // ************************************************************
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd_exp(input logic [7:0] a, input logic [32:0] e);
    rd_q.push_back(e);
    apb(1'b0, a, 32'h0000_0000);
  endtask

  // software polls bit 0 until busy clears, giving up after 200 reads
  task automatic poll(input logic [7:0] a);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, a, 32'h0000_0000);
      n++;
    end
    while (rd[0] !== 1'b0 && n < 200);
    check(n < 200, 1'b1);
  endtask

  task automatic rx_frame(input logic pok, input logic [15:0] q, input logic [1:0] r,
    input logic en, input logic pass);
    st_q.push_back({r[1] | ((pok & en) ? pass : r[0]), pok & en});
    rx_info <= '{done: 1'b1, pause_ok: pok, pause_quanta: q, addr_pass: r[0],
      promiscuous: r[1]};
    @(posedge pclk);
    rx_info <= '0;
  endtask

  initial
  begin
    logic [4:0] idx;
    logic [31:0] dat;
    logic [31:0] acc;
    logic [15:0] pt;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_exp(mac_ctrl_pkg::OFF_PHY_ACCESS, 33'h0_0000_0000);
    rd_exp(mac_ctrl_pkg::OFF_PHY_DATA, 33'h0_0000_0000);
    rd_exp(mac_ctrl_pkg::OFF_PAUSE_CTRL, 33'h0_0000_0000);
    rd_exp(8'ha0, 33'h1_0000_0000);
    // ************************************************************
    // phy write then read back, with refused writes while busy
    // ************************************************************
    repeat (4)
    begin
      idx = 5'($random(seed));
      dat = $random(seed);
      delay <= 4'h4 | 4'($random(seed));
      apb(1'b1, mac_ctrl_pkg::OFF_PHY_DATA, dat);
      acc = {16'h0000, 5'b00001, idx, 4'h0, 1'b1, 1'b1};
      apb(1'b1, mac_ctrl_pkg::OFF_PHY_ACCESS, acc);
      check({phy_req.valid, phy_req.write, phy_req.phy_addr, phy_req.reg_index},
        {1'b1, 1'b1, 5'b00001, idx});
      rd_exp(mac_ctrl_pkg::OFF_PHY_ACCESS, {1'b0, acc});
      apb(1'b1, mac_ctrl_pkg::OFF_PHY_DATA, ~dat);
      poll(mac_ctrl_pkg::OFF_PHY_ACCESS);
      check(phy_link_model_i.regs[idx], dat[15:0]);
      apb(1'b1, mac_ctrl_pkg::OFF_PHY_DATA, 32'h0000_0000);
      apb(1'b1, mac_ctrl_pkg::OFF_PHY_ACCESS, acc & 32'hffff_fffd);
      poll(mac_ctrl_pkg::OFF_PHY_ACCESS);
      rd_exp(mac_ctrl_pkg::OFF_PHY_DATA, {17'h0_0000, dat[15:0]});
    end
    // ************************************************************
    // pause frame send, every setting of bits 2:1
    // ************************************************************
    for (int k = 0; k < 4; k++)
    begin
      pt = 16'($random(seed));
      acc = {pt, 13'h0000, 2'(k), 1'b1};
      apb(1'b1, mac_ctrl_pkg::OFF_PAUSE_CTRL, acc);
      check(pause_tx_time, pt);
      rd_exp(mac_ctrl_pkg::OFF_PAUSE_CTRL, {1'b0, acc});
      apb(1'b1, mac_ctrl_pkg::OFF_PAUSE_CTRL, 32'h0000_0000);
      poll(mac_ctrl_pkg::OFF_PAUSE_CTRL);
      rd_exp(mac_ctrl_pkg::OFF_PAUSE_CTRL, {1'b0, acc & 32'hffff_fffe});
      check(pause_tx_req, 1'b0);
    end
    // ************************************************************
    // receive: enable, pass, duplex and pause_ok in all combinations
    // ************************************************************
    for (int k = 0; k < 16; k++)
    begin
      full_duplex <= k[2];
      apb(1'b1, mac_ctrl_pkg::OFF_PAUSE_CTRL, {29'h0, k[1], k[0], 1'b0});
      rx_frame(k[3], 16'h0002, 2'($random(seed)), k[0], k[1]);
      repeat (3) @(posedge pclk);
      check(tx_pause_stall, k[3] & k[0] & k[2]);
      repeat (12) @(posedge pclk);
      check(tx_pause_stall, k[3] & k[0] & k[2]);
      repeat (9) @(posedge pclk);
      check(tx_pause_stall, 1'b0);
    end
    // a second pause in mid-stall reloads the count
    rx_frame(1'b1, 16'h0002, 2'b00, 1'b1, 1'b1);
    repeat (10) @(posedge pclk);
    rx_frame(1'b1, 16'h0002, 2'b00, 1'b1, 1'b1);
    repeat (13) @(posedge pclk);
    check(tx_pause_stall, 1'b1);
    repeat (12) @(posedge pclk);
    // fast link: one quantum lasts 512 cycles
    speed_100 <= 1'b1;
    rx_frame(1'b1, 16'h0001, 2'b00, 1'b1, 1'b1);
    repeat (300) @(posedge pclk);
    check(tx_pause_stall, 1'b1);
    repeat (220) @(posedge pclk);
    check(tx_pause_stall, 1'b0);
    results();
  end
endmodule
